// ### rtl/tag_host.sv
// host controller that drives an asynchronous cache tag memory with comparator
`timescale 1ns/1ps

module tag_host
  import tag_host_pkg::*;
#(
  parameter int IDX_W = INDEX_W,
  parameter int DAT_W = DATA_W
)
(
  input  wire logic               mclk,
  input  wire logic               rst_n,
  // user command port
  input  wire logic               cmd_valid,
  input  wire op_type             cmd_op,
  input  wire logic [IDX_W-1:0]   cmd_index,
  input  wire logic [DAT_W-1:0]   cmd_data,
  output logic                    cmd_ready,
  output logic                    done,
  output logic                    hit,
  output logic [DAT_W-1:0]        rd_data,
  // memory pins
  output logic                    chip_sel_n,
  output logic                    out_en_n,
  output logic                    wr_strobe_n,
  output logic                    flash_clear_n,
  output logic [IDX_W-1:0]        index_in,
  output logic [DAT_W-1:0]        tag_data_out,
  output logic                    tag_data_oe,
  input  wire logic [DAT_W-1:0]   tag_data_lanes,
  input  wire logic               match_in
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (IDX_W < 1 || IDX_W > 24 || DAT_W < 1 || DAT_W > 64)
  begin : g_bad_width
    $error("tag_host: unsupported pin width");
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_WR_LOW, ST_WR_END, ST_CMP, ST_RD, ST_CLR_LOW, ST_CLR_TAIL, ST_GAP
  } state_type;

  state_type        state;
  state_type        next_state;
  op_type           op;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  // next state; every timed state waits cnt down to zero
  always_comb
  begin
    next_state = state;
    next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
    case (state)
      ST_IDLE:
      begin
        // ready gates the take, so the edge right after reset refuses a request
        if (cmd_valid && cmd_ready && cmd_op == OP_CLEAR)
        begin
          next_state = ST_CLR_LOW;
          next_cnt   = CNT_W'(CLR_PULSE_CYC - 1);
        end
        else if (cmd_valid && cmd_ready)
          next_state = ST_SETUP;
      end
      ST_SETUP:
      begin
        // index settled one cycle with select high before any strobe
        case (op)
          OP_WRITE:
          begin
            next_state = ST_WR_LOW;
            next_cnt   = CNT_W'(WR_PULSE_CYC - 1);
          end
          OP_COMPARE:
          begin
            next_state = ST_CMP;
            next_cnt   = CNT_W'(CMP_VALID_CYC - 1);
          end
          default:
          begin
            next_state = ST_RD;
            next_cnt   = CNT_W'(RD_ACCESS_CYC - 1);
          end
        endcase
      end
      ST_WR_LOW:
        if (cnt == '0)
          next_state = ST_WR_END;
      ST_WR_END:
      begin
        next_state = ST_GAP;
        next_cnt   = CNT_W'(RELEASE_CYC - 1);
      end
      ST_CMP, ST_RD:
        if (cnt == '0)
        begin
          next_state = ST_GAP;
          next_cnt   = CNT_W'(RELEASE_CYC - 1);
        end
      ST_CLR_LOW:
        if (cnt == '0)
        begin
          next_state = ST_CLR_TAIL;
          next_cnt   = CNT_W'(CLR_TAIL_CYC - 1);
        end
      ST_CLR_TAIL:
        if (cnt == '0)
          next_state = ST_IDLE;
      ST_GAP:
        if (cnt == '0)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // state, counter and captured command
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      cnt   <= '0;
      op    <= OP_WRITE;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      if (state == ST_IDLE && cmd_valid && cmd_ready)
        op <= cmd_op;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, registered from next_state
  // ----------------------------------------------------------------
  // select and strobe fall together and rise together, so the write
  // window is the same whichever edge the device treats as limiting
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      chip_sel_n    <= 1'b1;
      wr_strobe_n   <= 1'b1;
      out_en_n      <= 1'b1;
      flash_clear_n <= 1'b1;
    end
    else
    begin
      chip_sel_n    <= !(next_state == ST_WR_LOW || next_state == ST_CMP
                         || next_state == ST_RD);
      wr_strobe_n   <= !(next_state == ST_WR_LOW);
      out_en_n      <= !(next_state == ST_RD);
      flash_clear_n <= !(next_state == ST_CLR_LOW);
    end
  end

  // index only moves while idle, when select and strobe are high
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      index_in <= '0;
    else if (state == ST_IDLE && cmd_valid && cmd_ready)
      index_in <= cmd_index;
  end

  // lanes are driven for writes and compares only, held through write end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tag_data_out <= '0;
      tag_data_oe  <= 1'b0;
    end
    else
    begin
      if (state == ST_IDLE && cmd_valid && cmd_ready)
        tag_data_out <= cmd_data;
      tag_data_oe <= (next_state == ST_WR_LOW || next_state == ST_WR_END
                      || next_state == ST_CMP);
    end
  end

  // ----------------------------------------------------------------
  // user side results
  // ----------------------------------------------------------------
  // match is open drain with a pull-up: high means hit
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      hit       <= 1'b0;
      rd_data   <= '0;
      done      <= 1'b0;
      cmd_ready <= 1'b0;
    end
    else
    begin
      if (state == ST_CMP && cnt == '0)
        hit <= match_in;
      if (state == ST_RD && cnt == '0)
        rd_data <= tag_data_lanes;
      done      <= (next_state == ST_IDLE && state != ST_IDLE);
      cmd_ready <= (next_state == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_IDX_STABLE: assert property (@(posedge mclk) disable iff (!rst_n)
    (!chip_sel_n && !wr_strobe_n) |-> $stable(index_in))
    else $error("index moved during write window");

  AST_NO_CONTENTION: assert property (@(posedge mclk) disable iff (!rst_n)
    tag_data_oe |-> out_en_n && $past(out_en_n))
    else $error("lanes driven while device may drive them");

  AST_WR_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(wr_strobe_n) |-> (!wr_strobe_n && !chip_sel_n) [*4] ##1 (wr_strobe_n && chip_sel_n))
    else $error("write pulse length wrong");

  AST_WR_DATA: assert property (@(posedge mclk) disable iff (!rst_n)
    ($rose(wr_strobe_n) && $past(rst_n)) |-> tag_data_oe && $past(tag_data_oe) && $past(tag_data_oe, 2))
    else $error("write data not held across end of write");

  AST_CLR_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(flash_clear_n) |-> !flash_clear_n [*8] ##1 !flash_clear_n [*4] ##1 flash_clear_n)
    else $error("clear pulse length wrong");

  AST_CLR_QUIET: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(flash_clear_n) |-> chip_sel_n && !cmd_ready ##1 chip_sel_n)
    else $error("operation started inside clear cycle");

  AST_CMP_WAIT: assert property (@(posedge mclk) disable iff (!rst_n)
    ($fell(chip_sel_n) && out_en_n && wr_strobe_n) |-> tag_data_oe [*5] ##1 chip_sel_n)
    else $error("compare window wrong length");

  AST_DONE_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
    done |-> cmd_ready && chip_sel_n && flash_clear_n ##1 !done)
    else $error("done not a single idle pulse");

  AST_RD_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(out_en_n) |-> !tag_data_oe [*2])
    else $error("lanes driven too soon after read");

endmodule : tag_host

// ### rtl/tag_host_pkg.sv
// constants and types shared by the tag memory host controller
package tag_host_pkg;

  // ----------------------------------------------------------------
  // clock and pin widths
  // ----------------------------------------------------------------
  localparam int CLK_PS  = 8000;
  localparam int INDEX_W = 13;
  localparam int DATA_W  = 8;

  // ----------------------------------------------------------------
  // timing figures in ns, slowest grade
  // ----------------------------------------------------------------
  localparam int WR_PULSE_NS  = 25;   // write pulse and select to end of write
  localparam int DATA_SU_NS   = 15;   // data valid to end of write
  localparam int CMP_VALID_NS = 35;   // index to match valid
  localparam int RD_ACCESS_NS = 35;   // index to read data valid
  localparam int RELEASE_NS   = 12;   // select or enable release to high impedance
  localparam int CLR_PULSE_NS = 95;   // clear pulse width
  localparam int CLR_CYCLE_NS = 100;  // full clear cycle
  localparam int CLR_REC_NS   = 5;    // clear rise to inputs valid

  // ----------------------------------------------------------------
  // cycle counts, least times rounded up
  // ----------------------------------------------------------------
  localparam int WR_PULSE_CYC  = (WR_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int DATA_SU_CYC   = (DATA_SU_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CMP_VALID_CYC = (CMP_VALID_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RD_ACCESS_CYC = (RD_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RELEASE_CYC   = (RELEASE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLR_PULSE_CYC = (CLR_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLR_CYCLE_CYC = (CLR_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLR_REC_CYC   = (CLR_REC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLR_TAIL_CYC  = (CLR_CYCLE_CYC - CLR_PULSE_CYC > CLR_REC_CYC) ?
                                 (CLR_CYCLE_CYC - CLR_PULSE_CYC) : CLR_REC_CYC;
  localparam int CNT_W         = 5;

  // ----------------------------------------------------------------
  // user commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_WRITE, OP_COMPARE, OP_READ, OP_CLEAR} op_type;

endpackage : tag_host_pkg

// ### verif/tag_mem_model.sv
// behavioural model of the asynchronous tag memory with comparator
`timescale 1ns/1ps
module tag_mem_model
  import tag_host_pkg::*;
#(
  parameter int ACC_NS = 35
)
(
  input  wire logic               chip_sel_n,
  input  wire logic               out_en_n,
  input  wire logic               wr_strobe_n,
  input  wire logic               flash_clear_n,
  input  wire logic [INDEX_W-1:0] index_in,
  input  wire logic [DATA_W-1:0]  lanes,
  output logic                    match_pin,
  output logic [DATA_W-1:0]       q_out,
  output logic                    q_drive
);
  logic [DATA_W-1:0] mem [0:(1<<INDEX_W)-1];
  logic              cmp_ok;
  logic              cmp_late;
  logic              clr_settled;

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  // level sensitive: a write spans the later fall to the first rise
  always @(flash_clear_n or clr_settled or chip_sel_n or wr_strobe_n or index_in or lanes)
  begin
    if (!flash_clear_n)
    begin
      foreach (mem[i])
        mem[i] = '0;
    end
    else if (clr_settled && !chip_sel_n && !wr_strobe_n)
      mem[index_in] = lanes;
  end

  // writes and compares stay ignored for the recovery time after clear rises; reads are not held off
  assign #(CLR_REC_NS) clr_settled = flash_clear_n;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // released match reads high through the pull-up; result only after full access
  assign cmp_ok = flash_clear_n && clr_settled && !chip_sel_n && wr_strobe_n
                  && out_en_n;
  assign #(ACC_NS) cmp_late = cmp_ok;
  assign match_pin = (cmp_ok && cmp_late) ? (mem[index_in] == lanes) : 1'b1;
  // lanes driven in read only; strobe low floats them at once
  assign q_drive = flash_clear_n && !chip_sel_n && wr_strobe_n && !out_en_n;
  assign #(ACC_NS) q_out = mem[index_in];
endmodule : tag_mem_model

// ### verif/tb_tag_host.sv
// self-checking bench for the tag memory host controller
`timescale 1ns/1ps
module tb_tag_host;
  import tag_host_pkg::*;
  typedef struct {op_type op; logic [INDEX_W-1:0] idx; logic [DATA_W-1:0] d; logic exp;} row_type;
  logic               mclk = 1'b0;
  logic               rst_n = 1'b0;
  logic               cmd_valid = 1'b0;
  op_type             cmd_op = OP_WRITE;
  logic [INDEX_W-1:0] cmd_index = '0;
  logic [DATA_W-1:0]  cmd_data = '0;
  logic               cmd_ready, done, hit, chip_sel_n, out_en_n, wr_strobe_n, flash_clear_n;
  logic               tag_data_oe, match_in, q_drive;
  logic [DATA_W-1:0]  rd_data, tag_data_out, tag_data_lanes, q_out;
  logic [INDEX_W-1:0] index_in, prev_idx;
  logic [DATA_W-1:0]  float_pat = 8'h55;
  int                 error_cnt = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  int                 held = 0;
  int                 clr_low = 0;
  row_type            rows [13] = '{
    '{OP_WRITE, 13'h0000, 8'hA5, 1'b0}, '{OP_WRITE, 13'h1FFF, 8'h3C, 1'b0}, '{OP_WRITE, 13'h0001, 8'h5A, 1'b0},
    '{OP_COMPARE, 13'h0000, 8'hA5, 1'b1}, '{OP_COMPARE, 13'h0000, 8'hA4, 1'b0},
    '{OP_COMPARE, 13'h0000, 8'h25, 1'b0}, '{OP_READ, 13'h1FFF, 8'h3C, 1'b0}, '{OP_READ, 13'h0001, 8'h5A, 1'b0},
    '{OP_COMPARE, 13'h1FFF, 8'h3C, 1'b1}, '{OP_CLEAR, 13'h0000, 8'h00, 1'b0},
    '{OP_COMPARE, 13'h0000, 8'h00, 1'b1}, '{OP_READ, 13'h1FFF, 8'h00, 1'b0}, '{OP_COMPARE, 13'h0001, 8'h5A, 1'b0}};

  always #4 mclk = ~mclk;
  // lanes float to a changing pattern so stale values never look valid
  always @(posedge mclk) float_pat <= ~float_pat;
  assign tag_data_lanes = tag_data_oe ? tag_data_out : (q_drive ? q_out : float_pat);

  tag_host dut (.mclk, .rst_n, .cmd_valid, .cmd_op, .cmd_index, .cmd_data, .cmd_ready, .done, .hit, .rd_data,
    .chip_sel_n, .out_en_n, .wr_strobe_n, .flash_clear_n, .index_in, .tag_data_out, .tag_data_oe,
    .tag_data_lanes, .match_in);
  tag_mem_model mdl (.chip_sel_n, .out_en_n, .wr_strobe_n, .flash_clear_n, .index_in, .lanes(tag_data_lanes),
    .match_pin(match_in), .q_out, .q_drive);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // one command, back to back with the previous one when called in a row
  task automatic run(input row_type r);
    int n;
    n = 0;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = r.op;
    cmd_index = r.idx;
    cmd_data = r.d;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("latency", 16'(n), (r.op == OP_CLEAR) ? 16'h000E : 16'h0009);
    if (r.op == OP_COMPARE)
      check("hit", 16'(hit), 16'(r.exp));
    if (r.op == OP_READ)
      check("rd_data", 16'(rd_data), 16'(r.d));
  endtask : run

  // ----------------------------------------------------------------
  // pin watch and timeout
  // ----------------------------------------------------------------
  // sampled mid-cycle where registered pins have settled
  always @(negedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      wrap_up();
    end
    if (rst_n)
    begin
      check("contention", 16'(tag_data_oe & q_drive), 16'h0000);
      if (!chip_sel_n && !wr_strobe_n)
        check("index frozen", 16'(index_in), 16'(prev_idx));
      // judge the pulse before the count is cleared for the next one
      if (wr_strobe_n && held > 0)
        check("data setup", 16'(held >= DATA_SU_CYC), 16'h0001);
      held = (!wr_strobe_n && tag_data_oe) ? held + 1 : 0;
      if (flash_clear_n && clr_low > 0)
        check("clear width", 16'(clr_low >= CLR_PULSE_CYC), 16'h0001);
      clr_low = flash_clear_n ? 0 : clr_low + 1;
    end
    prev_idx = index_in;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge mclk);
    check("reset pins",
      16'({cmd_ready, done, chip_sel_n, out_en_n, wr_strobe_n, flash_clear_n, tag_data_oe}), 16'h001E);
    rst_n = 1'b1;
    foreach (rows[i])
      run(rows[i]);
    // reset lands in the middle of a write pulse
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = OP_WRITE;
    cmd_index = 13'h0005;
    cmd_data = 8'hFF;
    @(negedge mclk);
    cmd_valid = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    check("mid reset pins",
      16'({cmd_ready, done, chip_sel_n, out_en_n, wr_strobe_n, flash_clear_n, tag_data_oe}), 16'h001E);
    rst_n = 1'b1;
    run(rows[10]);
    run(rows[1]);
    run(rows[6]);
    wrap_up();
  end
endmodule : tb_tag_host
